// >>> design/csm_top.sv
// control-source select: register bank and pin/register steering of switch settings
// assumes control pins and serial lines are synchronous to mclk_i; sda is open drain
`timescale 1ns/1ps

// Summary of operation
// - after power-up the mode field holds pin-only encoding until software changes it
// - reset returns every configuration register to its default
// - after reset switch, emphasis and boost follow the control pins
// - mixed mode keeps switch connectivity on lane, loop and dual-copy pins
// - mixed mode lets registers replace pin emphasis and boost settings
// - serial mode drives everything from registers and ignores control pins
// - device is only a serial target; address upper four bits are 1010
// - low three address bits equal the board-driven address select pins
// - mode field is bits 1:0 at 0x0F, reset 0x00, 00 means pins only
// - register control offers ten boost settings, pins only two
// - register control gives four output levels; pins fix 400 mV
// - register control gives eight emphasis settings and programmable loss detection
// - reset input is active low
module csm_top
  import csm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] addr_sel_i,
  input wire logic [1:0] lane_sel_pins_i,
  input wire logic dual_copy_pin_i,
  input wire logic [2:0] port_loop_pins_i,
  input wire logic [2:0] tx_emphasis_pins_i,
  input wire logic [2:0] rx_boost_pins_i,
  output logic [1:0] mode_o,
  output logic [1:0] lane_sel_o,
  output logic dual_copy_o,
  output logic [2:0] port_loop_o,
  output logic [8:0] tx_emphasis_o,
  output logic [11:0] rx_boost_o,
  output logic [5:0] out_level_o,
  output logic [8:0] signal_loss_detect_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic sw_from_pins(input logic [1:0] m);
    return m != MODE_SER;
  endfunction : sw_from_pins

  // the undefined encoding falls back to pins, the safe choice
  function automatic logic ana_from_pins(input logic [1:0] m);
    return m == MODE_PIN || m == MODE_UNDEF;
  endfunction : ana_from_pins

  function automatic logic in_bank(input logic [7:0] a);
    return a >= 8'(IDX_SW) && a <= 8'(IDX_LAST);
  endfunction : in_bank

  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a == 8'(IDX_SW)) begin
      return SW_WMASK;
    end else if (a < 8'(IDX_TX0)) begin
      return RX_WMASK;
    end
    return TX_WMASK;
  endfunction : wmask

  // ten boost settings: codes above the top one saturate
  function automatic logic [3:0] clamp_boost(input logic [3:0] v);
    return (v > RX_BOOST_MAX) ? RX_BOOST_MAX : v;
  endfunction : clamp_boost

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  csm_reg_if bus ();
  logic sda_o_r;

  csm_i2c_target u_target (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .addr_sel_i(addr_sel_i),
    .sda_oe_o(sda_oe_o),
    .bus(bus.master)
  );

  // open drain: the driven level is always low
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_o_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0;
    end
  end
  assign sda_o = sda_o_r;

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [1:0] mode_r;
  logic [7:0] reg_r [IDX_SW:IDX_LAST];
  logic [7:0] status;
  logic [7:0] rd_val;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r <= MODE_RST;
    end else if (bus.wr_stb && bus.addr == ADDR_MODE) begin
      // upper bits are dropped, so they read back as zero
      mode_r <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_r[IDX_SW] <= SW_RST;
      for (int p = 0; p < NPORT; p++) begin
        reg_r[IDX_RX0 + p] <= RX_RST;
        reg_r[IDX_TX0 + p] <= TX_RST;
      end
    end else if (bus.wr_stb && in_bank(bus.addr)) begin
      reg_r[bus.addr[2:0]] <= bus.wdata & wmask(bus.addr);
    end
  end

  assign status = {6'h00, ~ana_from_pins(mode_r), ~sw_from_pins(mode_r)};

  always_comb begin
    rd_val = 8'h00;
    if (in_bank(bus.addr)) begin
      rd_val = reg_r[bus.addr[2:0]];
    end else if (bus.addr == ADDR_MODE) begin
      rd_val = {6'h00, mode_r};
    end else if (bus.addr == ADDR_STATUS) begin
      rd_val = status;
    end
  end
  assign bus.rdata = rd_val;

  // ----------------------------------------------------------------
  // switch connectivity steering
  // ----------------------------------------------------------------
  logic [1:0] sel_r;
  logic dual_r;
  logic [2:0] loop_r;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_r <= 2'h0;
      dual_r <= 1'b0;
      loop_r <= 3'h0;
    end else if (sw_from_pins(mode_r)) begin
      sel_r <= lane_sel_pins_i;
      dual_r <= dual_copy_pin_i;
      loop_r <= port_loop_pins_i;
    end else begin
      sel_r <= reg_r[IDX_SW][SW_SEL_LSB +: 2];
      dual_r <= reg_r[IDX_SW][SW_DUAL_BIT];
      loop_r <= reg_r[IDX_SW][SW_LOOP_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // per-port analog settings
  // ----------------------------------------------------------------
  logic [8:0] pe_r;
  logic [11:0] boost_r;
  logic [5:0] lvl_r;
  logic [8:0] sld_r;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pe_r[gp*3 +: 3] <= 3'h0;
          boost_r[gp*4 +: 4] <= 4'h0;
          lvl_r[gp*2 +: 2] <= LVL_400;
          sld_r[gp*3 +: 3] <= SLD_PIN;
        end else if (ana_from_pins(mode_r)) begin
          pe_r[gp*3 +: 3] <= tx_emphasis_pins_i[gp] ? PIN_PE_HI : 3'h0;
          boost_r[gp*4 +: 4] <= rx_boost_pins_i[gp] ? PIN_BOOST_HI : 4'h0;
          lvl_r[gp*2 +: 2] <= LVL_400;
          sld_r[gp*3 +: 3] <= SLD_PIN;
        end else begin
          pe_r[gp*3 +: 3] <= reg_r[IDX_TX0 + gp][TX_PE_LSB +: 3];
          boost_r[gp*4 +: 4] <= clamp_boost(reg_r[IDX_RX0 + gp][RX_BOOST_LSB +: 4]);
          lvl_r[gp*2 +: 2] <= reg_r[IDX_TX0 + gp][TX_LVL_LSB +: 2];
          sld_r[gp*3 +: 3] <= reg_r[IDX_RX0 + gp][RX_SLD_LSB +: 3];
        end
      end
    end
  endgenerate

  assign mode_o = mode_r;
  assign lane_sel_o = sel_r;
  assign dual_copy_o = dual_r;
  assign port_loop_o = loop_r;
  assign tx_emphasis_o = pe_r;
  assign rx_boost_o = boost_r;
  assign out_level_o = lvl_r;
  assign signal_loss_detect_o = sld_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mode_rst;
    @(posedge mclk_i) $rose(rst_b_i) |-> mode_r == MODE_PIN;
  endproperty
  a_mode_rst: assert property (p_mode_rst) else $error("mode not pin-only after reset");

  property p_regs_rst;
    @(posedge mclk_i) $rose(rst_b_i) |->
      reg_r[IDX_SW] == SW_RST && reg_r[IDX_RX0] == RX_RST && reg_r[IDX_TX0] == TX_RST;
  endproperty
  a_regs_rst: assert property (p_regs_rst) else $error("register default lost");

  // the release edge still loads reset values, so attempts start only once out of reset
  property p_pin_sw;
    @(posedge mclk_i) disable iff (!rst_b_i)
      rst_b_i && mode_r == MODE_PIN
      |=> sel_r == $past(lane_sel_pins_i) && dual_r == $past(dual_copy_pin_i);
  endproperty
  a_pin_sw: assert property (p_pin_sw) else $error("switch not from pins");

  property p_pin_boost;
    @(posedge mclk_i) disable iff (!rst_b_i)
      rst_b_i && mode_r == MODE_PIN && rx_boost_pins_i[0] |=> boost_r[3:0] == PIN_BOOST_HI;
  endproperty
  a_pin_boost: assert property (p_pin_boost) else $error("boost not from pin");

  property p_mix_sw;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r == MODE_MIX |=> loop_r == $past(port_loop_pins_i);
  endproperty
  a_mix_sw: assert property (p_mix_sw) else $error("mixed loopback not from pins");

  property p_mix_pe;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r == MODE_MIX |=> pe_r[2:0] == $past(reg_r[IDX_TX0][2:0]);
  endproperty
  a_mix_pe: assert property (p_mix_pe) else $error("mixed emphasis not from register");

  property p_ser_sw;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r == MODE_SER |=>
        loop_r == $past(reg_r[IDX_SW][6:4]) && sel_r == $past(reg_r[IDX_SW][1:0]);
  endproperty
  a_ser_sw: assert property (p_ser_sw) else $error("serial switch follows pins");

  property p_mode_wr;
    @(posedge mclk_i) disable iff (!rst_b_i)
      bus.wr_stb && bus.addr == ADDR_MODE |=> mode_r == $past(bus.wdata[1:0]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write not stored");

  property p_boost_sat;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r[1] && reg_r[IDX_RX0 + 1][3:0] > RX_BOOST_MAX |=> boost_r[7:4] == RX_BOOST_MAX;
  endproperty
  a_boost_sat: assert property (p_boost_sat) else $error("boost beyond ten settings");

  property p_pin_lvl;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r == MODE_PIN |=> lvl_r == {LVL_400, LVL_400, LVL_400};
  endproperty
  a_pin_lvl: assert property (p_pin_lvl) else $error("pin level not 400 mV");

  property p_ser_sld;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r == MODE_SER |=> sld_r[2:0] == $past(reg_r[IDX_RX0][6:4]);
  endproperty
  a_ser_sld: assert property (p_ser_sld) else $error("loss detect not from register");

  // a settled serial mode leaves pin changes unseen
  sequence s_ser_settled;
    mode_r == MODE_SER && $past(mode_r) == MODE_SER && $stable(reg_r[IDX_SW]);
  endsequence

  property p_ser_blind;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_ser_settled |=> $stable(sel_r) && $stable(dual_r) && $stable(loop_r);
  endproperty
  a_ser_blind: assert property (p_ser_blind) else $error("serial switch moved with pins");

  property p_mix_boost;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r == MODE_MIX && reg_r[IDX_RX0][3:0] <= RX_BOOST_MAX
      |=> boost_r[3:0] == $past(reg_r[IDX_RX0][3:0]);
  endproperty
  a_mix_boost: assert property (p_mix_boost) else $error("mixed boost not from register");

  property p_mix_sld;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mode_r == MODE_MIX |=> sld_r[5:3] == $past(reg_r[IDX_RX0 + 1][6:4]);
  endproperty
  a_mix_sld: assert property (p_mix_sld) else $error("mixed loss detect not from register");

endmodule : csm_top

// >>> design/csm_pkg.sv
// constants, encodings and register layout of the control-source select block
// assumes one 100 MHz clock; every control pin is already synchronous to it
package csm_pkg;

  // ----------------------------------------------------------------
  // serial target address
  // ----------------------------------------------------------------
  localparam logic [3:0] I2C_ADDR_HI = 4'ha;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // register map (byte address = register index)
  // ----------------------------------------------------------------
  localparam int NPORT = 3;
  localparam int IDX_SW = 1;
  localparam int IDX_RX0 = 2;
  localparam int IDX_TX0 = 5;
  localparam int IDX_LAST = IDX_TX0 + NPORT - 1;
  localparam logic [7:0] ADDR_MODE = 8'h0f;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] SW_RST = 8'h00;
  localparam logic [7:0] RX_RST = 8'h00;
  localparam logic [7:0] TX_RST = 8'h20;

  // writable bits; the rest read as zero
  localparam logic [7:0] SW_WMASK = 8'h77;
  localparam logic [7:0] RX_WMASK = 8'h7f;
  localparam logic [7:0] TX_WMASK = 8'h37;

  // field positions
  localparam int SW_SEL_LSB = 0;
  localparam int SW_DUAL_BIT = 2;
  localparam int SW_LOOP_LSB = 4;
  localparam int RX_BOOST_LSB = 0;
  localparam int RX_SLD_LSB = 4;
  localparam int TX_PE_LSB = 0;
  localparam int TX_LVL_LSB = 4;

  // register boost limit and values used when settings come from pins
  localparam logic [3:0] RX_BOOST_MAX = 4'h9;
  localparam logic [3:0] PIN_BOOST_HI = 4'h5;
  localparam logic [2:0] PIN_PE_HI = 3'h4;
  localparam logic [1:0] LVL_400 = 2'h2;
  localparam logic [2:0] SLD_PIN = 3'h1;

  typedef enum logic [1:0] {
    MODE_PIN = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_MIX = 2'b10,
    MODE_SER = 2'b11
  } csm_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TXACK = 3'b100
  } csm_i2c_st_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR = 2'b01,
    PH_DATA = 2'b10
  } csm_phase_t;

endpackage : csm_pkg

// >>> design/csm_reg_if.sv
// register access carrier between the serial target and the register bank
// assumes the bank answers rdata combinationally from addr
`timescale 1ns/1ps
interface csm_reg_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface : csm_reg_if

// >>> design/csm_i2c_target.sv
// two-wire serial target: address match, pointer byte, auto-increment access
// assumes scl/sda are synchronous and slow against mclk_i (several clocks per phase)
`timescale 1ns/1ps
module csm_i2c_target
  import csm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [2:0] addr_sel_i,
  output logic sda_oe_o,
  csm_reg_if.master bus
);

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------
  logic scl_d_r;
  logic sda_d_r;
  csm_i2c_st_t st_r;
  csm_phase_t ph_r;
  logic [3:0] bits_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic oe_r;
  logic rw_r;
  logic wr_r;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] sel);
    return b[7:1] == {I2C_ADDR_HI, sel};
  endfunction : addr_hit

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_i;
      sda_d_r <= sda_i;
    end
  end

  assign scl_rise = scl_i & ~scl_d_r;
  assign scl_fall = ~scl_i & scl_d_r;
  assign start_ev = scl_i & scl_d_r & sda_d_r & ~sda_i;
  assign stop_ev = scl_i & scl_d_r & ~sda_d_r & sda_i;

  // ----------------------------------------------------------------
  // protocol
  // ----------------------------------------------------------------
  // sda is only ever pulled low; a one bit is sent by releasing the line
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ST_IDLE;
      ph_r <= PH_ADDR;
      bits_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      if (wr_r) begin
        ptr_r <= ptr_r + 8'h01;
      end
      if (start_ev) begin
        st_r <= ST_RX;
        ph_r <= PH_ADDR;
        bits_r <= 4'h0;
        oe_r <= 1'b0;
      end else if (stop_ev) begin
        st_r <= ST_IDLE;
        oe_r <= 1'b0;
      end else begin
        unique case (st_r)
          ST_IDLE: begin
          end
          ST_RX: begin
            if (scl_rise) begin
              rx_r <= {rx_r[6:0], sda_i};
              bits_r <= bits_r + 4'h1;
            end else if (scl_fall && bits_r == BYTE_BITS) begin
              bits_r <= 4'h0;
              if (ph_r == PH_ADDR && !addr_hit(rx_r, addr_sel_i)) begin
                st_r <= ST_IDLE;
              end else begin
                st_r <= ST_ACK;
                oe_r <= 1'b1;
                if (ph_r == PH_ADDR) begin
                  rw_r <= rx_r[0];
                end
                if (ph_r == PH_PTR) begin
                  ptr_r <= rx_r;
                end
                if (ph_r == PH_DATA) begin
                  wr_r <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (ph_r == PH_ADDR && rw_r) begin
                st_r <= ST_TX;
                tx_r <= bus.rdata;
                oe_r <= ~bus.rdata[7];
                ph_r <= PH_DATA;
              end else begin
                st_r <= ST_RX;
                oe_r <= 1'b0;
                ph_r <= (ph_r == PH_ADDR) ? PH_PTR : PH_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bits_r <= bits_r + 4'h1;
            end else if (scl_fall) begin
              if (bits_r == BYTE_BITS) begin
                bits_r <= 4'h0;
                oe_r <= 1'b0;
                st_r <= ST_TXACK;
                ptr_r <= ptr_r + 8'h01;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                oe_r <= ~tx_r[6];
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise && sda_i) begin
              st_r <= ST_IDLE;
            end else if (scl_fall) begin
              st_r <= ST_TX;
              tx_r <= bus.rdata;
              oe_r <= ~bus.rdata[7];
            end
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_oe_o = oe_r;
  assign bus.wr_stb = wr_r;
  assign bus.addr = ptr_r;
  assign bus.wdata = rx_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_addr_done;
    st_r == ST_RX && ph_r == PH_ADDR && scl_fall && bits_r == BYTE_BITS && !start_ev && !stop_ev;
  endsequence

  property p_hi_miss;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_addr_done ##0 (rx_r[7:4] != I2C_ADDR_HI) |=> st_r == ST_IDLE && !oe_r;
  endproperty
  a_hi_miss: assert property (p_hi_miss) else $error("foreign address acknowledged");

  property p_lo_hit;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_addr_done ##0 (rx_r[7:1] == {I2C_ADDR_HI, addr_sel_i}) |=> st_r == ST_ACK && oe_r;
  endproperty
  a_lo_hit: assert property (p_lo_hit) else $error("own address not acknowledged");

  property p_lo_miss;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_addr_done ##0 (rx_r[7:4] == I2C_ADDR_HI && rx_r[3:1] != addr_sel_i)
      |=> st_r == ST_IDLE;
  endproperty
  a_lo_miss: assert property (p_lo_miss) else $error("low address bits ignored");

endmodule : csm_i2c_target

// >>> verif/csm_i2c_master.sv
// serial bus master model that owns scl and sda on the board
// assumes sda has a pull-up, so a released line reads high
`timescale 1ns/1ps
module csm_i2c_master (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // bus idles released; a half period of 8 clocks keeps above the target minimum
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : hold
  // data only moves while scl is low
  task automatic put_bit(input logic b, output logic seen);
    hold(1);
    sda_low_o <= ~b;
    hold(4);
    scl_o <= 1'b1;
    hold(4);
    seen = sda_i;
    hold(4);
    scl_o <= 1'b0;
    hold(4);
  endtask : put_bit
  // also serves as repeated start
  task automatic start();
    hold(1);
    sda_low_o <= 1'b0;
    hold(4);
    scl_o <= 1'b1;
    hold(4);
    sda_low_o <= 1'b1;
    hold(4);
    scl_o <= 1'b0;
    hold(4);
  endtask : start
  task automatic stop();
    hold(1);
    sda_low_o <= 1'b1;
    hold(4);
    scl_o <= 1'b1;
    hold(4);
    sda_low_o <= 1'b0;
    hold(4);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(nack, s);
  endtask : rbyte
endmodule : csm_i2c_master

// >>> verif/csm_top_tb.sv
// self-checking bench for the control-source select block
// assumes a pulled-up sda wire shared by the master model and the target
`timescale 1ns/1ps
module csm_top_tb;
  logic mclk, rst_b, scl, sda_low, sda, sda_o, sda_oe, dual_pin, dual;
  logic [2:0] addr_sel, loop_pins, pe_pins, boost_pins, loop;
  logic [1:0] lane_pins, mode, lane;
  logic [8:0] pe, sld;
  logic [11:0] boost;
  logic [5:0] lvl;
  int failures, comparisons;
  assign sda = ~sda_low & ~(sda_oe & ~sda_o);
  csm_top DUT (.mclk_i(mclk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .addr_sel_i(addr_sel), .lane_sel_pins_i(lane_pins),
    .dual_copy_pin_i(dual_pin), .port_loop_pins_i(loop_pins), .tx_emphasis_pins_i(pe_pins),
    .rx_boost_pins_i(boost_pins), .mode_o(mode), .lane_sel_o(lane), .dual_copy_o(dual),
    .port_loop_o(loop), .tx_emphasis_o(pe), .rx_boost_o(boost), .out_level_o(lvl),
    .signal_loss_detect_o(sld));
  csm_i2c_master m (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    m.start();
    m.wbyte({4'ha, addr_sel, 1'b0}, k0);
    m.wbyte(a, k1);
    m.wbyte(d, k2);
    m.stop();
    check("write ack", {k0, k1, k2}, 3'h7);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    logic k0, k1, k2;
    m.start();
    m.wbyte({4'ha, addr_sel, 1'b0}, k0);
    m.wbyte(a, k1);
    m.start();
    m.wbyte({4'ha, addr_sel, 1'b1}, k2);
    m.rbyte(1'b1, d);
    m.stop();
    check("read ack", {k0, k1, k2}, 3'h7);
  endtask : reg_rd
  // order: lane(2) dual(1) loop(3) emphasis(3) boost(3)
  task automatic set_pins(input logic [11:0] v);
    @(posedge mclk);
    {lane_pins, dual_pin, loop_pins, pe_pins, boost_pins} <= v;
    repeat (2) @(posedge mclk);
  endtask : set_pins
  task automatic chk_sw_pins();
    check("lane_sel", lane, lane_pins);
    check("dual_copy", dual, dual_pin);
    check("port_loop", loop, loop_pins);
  endtask : chk_sw_pins
  task automatic chk_ana_pins();
    logic [8:0] e;
    logic [11:0] b;
    for (int p = 0; p < 3; p++) begin
      e[3*p+:3] = pe_pins[p] ? 3'h4 : 3'h0;
      b[4*p+:4] = boost_pins[p] ? 4'h5 : 4'h0;
    end
    check("tx_emphasis", pe, e);
    check("rx_boost", boost, b);
    check("out_level", lvl, 6'h2a);
    check("signal_loss", sld, 9'h049);
  endtask : chk_ana_pins
  task automatic chk_regs();
    check("tx_emphasis", pe, 9'h02f);
    check("rx_boost", boost, 12'h099);
    check("out_level", lvl, 6'h07);
    check("signal_loss", sld, 9'h03b);
  endtask : chk_regs
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    logic [7:0] d;
    check("mode", mode, 2'h0);
    set_pins(12'ha5c);
    chk_sw_pins();
    chk_ana_pins();
    set_pins(12'h5a3);
    chk_sw_pins();
    chk_ana_pins();
    for (int i = 0; i < 8; i++) begin
      reg_rd((i == 7) ? 8'h0f : 8'(i + 1), d);
      check("reg default", d, (i >= 4 && i < 7) ? 8'h20 : 8'h00);
    end
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_address();
    logic k;
    m.start();
    m.wbyte({4'ha, 3'h2, 1'b0}, k);
    m.stop();
    check("wrong low bits ack", k, 1'b0);
    m.start();
    m.wbyte({4'hb, addr_sel, 1'b0}, k);
    m.stop();
    check("wrong high bits ack", k, 1'b0);
    @(posedge mclk);
    addr_sel <= 3'h2;
    reg_wr(8'h01, 8'h75);
    $display("test address done");
  endtask : t_address
  task automatic t_mixed();
    reg_wr(8'h0f, 8'h02);
    check("mode", mode, 2'h2);
    reg_wr(8'h02, 8'h39);
    reg_wr(8'h03, 8'h7f);
    reg_wr(8'h04, 8'h00);
    reg_wr(8'h05, 8'h37);
    reg_wr(8'h06, 8'h15);
    reg_wr(8'h07, 8'h00);
    set_pins(12'h8ff);
    chk_sw_pins();
    chk_regs();
    set_pins(12'h300);
    chk_sw_pins();
    $display("test mixed done");
  endtask : t_mixed
  task automatic t_serial();
    logic [7:0] d;
    reg_wr(8'h0f, 8'h03);
    for (int i = 0; i < 2; i++) begin
      set_pins(i ? 12'hfff : 12'h000);
      check("lane_sel", lane, 2'h1);
      check("dual_copy", dual, 1'b1);
      check("port_loop", loop, 3'h7);
      chk_regs();
    end
    reg_rd(8'h0f, d);
    check("mode read", d, 8'h03);
    reg_rd(8'h10, d);
    check("status", d, 8'h03);
    $display("test serial done");
  endtask : t_serial
  task automatic t_reset();
    logic [7:0] d;
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    check("mode in reset", mode, 2'h0);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    check("mode", mode, 2'h0);
    set_pins(12'h6a5);
    chk_sw_pins();
    chk_ana_pins();
    reg_rd(8'h01, d);
    check("switch reg", d, 8'h00);
    reg_rd(8'h05, d);
    check("tx reg", d, 8'h20);
    $display("test reset done");
  endtask : t_reset
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    failures = 0;
    comparisons = 0;
    rst_b = 1'b0;
    addr_sel = 3'h5;
    {lane_pins, dual_pin, loop_pins, pe_pins, boost_pins} = 12'h000;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    t_defaults();
    t_address();
    t_mixed();
    t_serial();
    t_reset();
    final_report();
  end
  // the run needs about 12.7k clocks; the 30k-clock limit is over twice that
  initial begin
    #300_000;
    failures++;
    final_report();
  end
endmodule : csm_top_tb
